// [rtl/dpr_host.sv]
// Contract
// - Write only while select and write low
// - Write ends when either strobe rises
// - Data held past the ending strobe edge
// - Write strobe high through every read
// - Address-access read keeps select, drive low
// - Address valid before select falls
`timescale 1ns/1ps
module dpr_host
    import dpr_pkg::*;
#(
    parameter logic [ADDR_W-1:0] MBOX_ADDR = MBOX_ADDR_DEF
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              req_valid,
    input  wire dpr_req_t          req,
    output logic                   req_ready,
    output logic                   ack,
    output logic [DATA_W-1:0]      rdata,
    output logic                   mbox_flag,
    output logic                   mbox_sent,
    output dpr_pins_t              pins,
    input  wire logic [DATA_W-1:0] din,
    input  wire logic              busy_n,
    input  wire logic              int_n
);

    //--------------------------------------------------------------
    // Sequencer state
    //--------------------------------------------------------------
    dpr_state_t        state_r,  state_nxt;
    logic [CNT_W-1:0]  cnt_r,    cnt_nxt;
    dpr_req_t          cur_r,    cur_nxt;
    dpr_pins_t         pins_r,   pins_nxt;
    logic [DATA_W-1:0] rdata_r,  rdata_nxt;
    logic              flag_r,   flag_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        cur_nxt   = cur_r;
        pins_nxt  = pins_r;
        rdata_nxt = rdata_r;
        flag_nxt  = !int_n;
        case (state_r)
            DPR_IDLE:
            begin
                if (req_valid)
                begin
                    // Address and write data go out a cycle before
                    // any strobe falls
                    cur_nxt          = req;
                    pins_nxt.addr    = req.addr;
                    pins_nxt.dout    = req.wdata;
                    pins_nxt.dout_oe = req.we;
                    // Wait out the priority set-up before selecting
                    cnt_nxt          = T_PS_CYC - CNT_ONE;
                    state_nxt        = DPR_SETUP;
                end
            end
            DPR_SETUP:
            begin
                if (cnt_r != CNT_ZERO)
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
                else
                begin
                    pins_nxt.ce_n = 1'b0;
                    pins_nxt.we_n = !cur_r.we;
                    pins_nxt.oe_n = cur_r.we;
                    cnt_nxt   = cur_r.we ? T_PWE_CYC - CNT_ONE
                                         : T_AA_CYC - CNT_ONE;
                    state_nxt = DPR_STROBE;
                end
            end
            DPR_STROBE:
            begin
                if (!busy_n)
                begin
                    state_nxt = DPR_WAIT;
                end
                else if (cnt_r != CNT_ZERO)
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
                else
                begin
                    if (!cur_r.we)
                    begin
                        rdata_nxt = din;
                    end
                    // Both strobes rise together; data stays driven
                    pins_nxt.ce_n = 1'b1;
                    pins_nxt.we_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    state_nxt     = DPR_FINISH;
                end
            end
            DPR_WAIT:
            begin
                // Strobes stay low until the winner leaves
                if (busy_n)
                begin
                    cnt_nxt   = cur_r.we ? T_WH_CYC - CNT_ONE
                                         : T_BDD_CYC - CNT_ONE;
                    state_nxt = DPR_STROBE;
                end
            end
            DPR_FINISH:
            begin
                pins_nxt.dout_oe = 1'b0;
                state_nxt        = DPR_IDLE;
            end
            default:
            begin
                state_nxt = DPR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= DPR_IDLE;
            cnt_r   <= CNT_ZERO;
            cur_r   <= '0;
            pins_r  <= '{addr: ADDR_RST, ce_n: 1'b1, we_n: 1'b1,
                         oe_n: 1'b1, dout: DATA_RST, dout_oe: 1'b0};
            rdata_r <= DATA_RST;
            flag_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cur_r   <= cur_nxt;
            pins_r  <= pins_nxt;
            rdata_r <= rdata_nxt;
            flag_r  <= flag_nxt;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign pins      = pins_r;
    assign rdata     = rdata_r;
    assign mbox_flag = flag_r;
    assign req_ready = (state_r == DPR_IDLE);
    assign ack       = (state_r == DPR_FINISH);
    // A finished write to the mailbox raises the far port's flag
    assign mbox_sent = ack && cur_r.we && (cur_r.addr == MBOX_ADDR);

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    chk_we_only_sel: assert property (@(posedge clk) disable iff (!nrst)
        !pins.we_n |-> !pins.ce_n)
        else $error("write strobe low without select");

    chk_strobe_end: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pins.we_n) |-> pins.ce_n && state_r == DPR_FINISH)
        else $error("write did not end with both strobes");

    chk_data_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pins.we_n) |-> pins.dout_oe ##1 !pins.dout_oe)
        else $error("write data not held past strobe edge");

    chk_no_clash: assert property (@(posedge clk) disable iff (!nrst)
        !pins.oe_n |-> !pins.dout_oe)
        else $error("data driven while output drive low");

    chk_read_we: assert property (@(posedge clk) disable iff (!nrst)
        (!pins.oe_n || (state_r == DPR_STROBE && !cur_r.we))
        |-> pins.we_n)
        else $error("write strobe low during read");

    chk_addr_setup: assert property (@(posedge clk) disable iff (!nrst)
        $fell(pins.ce_n) |-> $stable(pins.addr))
        else $error("address changed as select fell");

    chk_read_len: assert property (@(posedge clk) disable iff (!nrst)
        $fell(pins.oe_n) |-> !pins.oe_n [*3] ##0 !pins.ce_n)
        else $error("read strobe shorter than access time");

    chk_write_len: assert property (@(posedge clk) disable iff (!nrst)
        $fell(pins.we_n) |-> !pins.we_n [*2])
        else $error("write pulse too short");

    chk_busy_hold: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == DPR_STROBE && !busy_n) |=> !ack [*2])
        else $error("access finished while busy");

    chk_busy_read: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == DPR_WAIT && busy_n && !cur_r.we)
        |=> !pins.oe_n [*3])
        else $error("read closed before access after busy");

    chk_flag_track: assert property (@(posedge clk) disable iff (!nrst)
        !int_n |=> mbox_flag)
        else $error("flag not reported");

endmodule : dpr_host

// [rtl/dpr_pkg.sv]
package dpr_pkg;

    //--------------------------------------------------------------
    // Port geometry
    //--------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 4;

    //--------------------------------------------------------------
    // Timing, fastest speed grade, in ns
    //--------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_AA_NS       = 25;
    localparam int unsigned T_PWE_NS      = 20;
    localparam int unsigned T_BDD_NS      = 25;
    localparam int unsigned T_WH_NS       = 20;
    localparam int unsigned T_PS_NS       = 5;

    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] T_AA_CYC  =
        CNT_W'((T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] T_PWE_CYC =
        CNT_W'((T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] T_BDD_CYC =
        CNT_W'((T_BDD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] T_WH_CYC  =
        CNT_W'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] T_PS_CYC  =
        CNT_W'((T_PS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;

    localparam logic [ADDR_W-1:0] MBOX_ADDR_DEF = 10'h3FF;
    localparam logic [ADDR_W-1:0] ADDR_RST      = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RST      = 8'h00;

    //--------------------------------------------------------------
    // Types
    //--------------------------------------------------------------
    typedef enum logic [2:0] {
        DPR_IDLE   = 3'h0,
        DPR_SETUP  = 3'h1,
        DPR_STROBE = 3'h3,
        DPR_FINISH = 3'h2,
        DPR_WAIT   = 3'h7
    } dpr_state_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpr_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic [DATA_W-1:0] dout;
        logic              dout_oe;
    } dpr_pins_t;

endpackage : dpr_pkg

// [verif/dpr_dev_model.sv]
`timescale 1ns/1ps
module dpr_dev_model
    import dpr_pkg::*;
(
    input  wire logic              clk,
    input  wire dpr_pins_t         pins,
    input  wire logic              far_wr,
    input  wire logic [ADDR_W-1:0] far_addr,
    input  wire logic [DATA_W-1:0] far_data,
    input  wire logic              clash,
    output logic [DATA_W-1:0]      din,
    output logic                   busy_n,
    output logic                   int_n
);
    // ----------------------------------------------------
    // One port of the shared array, far port by commands
    // ----------------------------------------------------
    logic [DATA_W-1:0] mem_r [2**ADDR_W];
    logic [DATA_W-1:0] last_r = 8'h00;
    logic [CNT_W-1:0]  age_r  = 4'h0;
    logic              flag_r = 1'b0;
    logic              rd;
    logic              rd_ok;
    assign rd = !pins.ce_n && !pins.oe_n && pins.we_n;
    assign busy_n = !(clash && !pins.ce_n);
    // Array data shows one access time after select and busy allow it
    assign rd_ok = rd && busy_n && (age_r >= T_AA_CYC - CNT_ONE);
    // Old data stays while busy, undriven pins show its inverse
    assign din = pins.dout_oe ? pins.dout :
                 rd_ok ? mem_r[pins.addr] :
                 (rd && !busy_n) ? last_r : ~last_r;
    // Flag driven high when clear, low while set
    assign int_n = flag_r ? 1'b0 : 1'b1;
    always @(posedge clk)
    begin
        if (!(rd && busy_n))
            age_r <= 4'h0;
        else if (age_r != 4'hF)
            age_r <= age_r + 4'h1;
        if (rd_ok)
            last_r <= mem_r[pins.addr];
        if (!pins.ce_n && !pins.we_n && busy_n)
            mem_r[pins.addr] <= pins.dout;
        if (far_wr)
            mem_r[far_addr] <= far_data;
        if (far_wr && far_addr == MBOX_ADDR_DEF)
            flag_r <= 1'b1;
        else if (!pins.ce_n && pins.addr == MBOX_ADDR_DEF)
            flag_r <= 1'b0;
    end
endmodule : dpr_dev_model

// [verif/test_dual_port_ram_busy_interrupt.sv]
`timescale 1ns/1ps
module test_dual_port_ram_busy_interrupt;
    import dpr_pkg::*;
    typedef struct packed {
        logic              rd;
        logic              sent;
        logic [DATA_W-1:0] data;
    } dpr_note_t;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              req_valid = 1'b0;
    dpr_req_t          req = '0;
    logic              req_ready, ack, mbox_flag, mbox_sent, busy_n, int_n;
    logic              far_wr = 1'b0;
    logic              clash = 1'b0;
    logic [ADDR_W-1:0] far_addr = '0;
    logic [DATA_W-1:0] far_data = '0;
    logic [DATA_W-1:0] rdata, din;
    logic [DATA_W-1:0] shadow [2**ADDR_W];
    logic [ADDR_W-1:0] adr [8];
    dpr_pins_t         pins;
    dpr_note_t         notes [$];
    dpr_note_t         head;
    int                miscompares = 0;
    int                checks = 0;
    int                seed = 32'h6803c572;
    always #5 clk = ~clk;
    dpr_host dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .ack(ack), .rdata(rdata),
        .mbox_flag(mbox_flag), .mbox_sent(mbox_sent), .pins(pins),
        .din(din), .busy_n(busy_n), .int_n(int_n));
    dpr_dev_model dev (.clk(clk), .pins(pins), .far_wr(far_wr),
        .far_addr(far_addr), .far_data(far_data), .clash(clash),
        .din(din), .busy_n(busy_n), .int_n(int_n));
    // ----------------------------------------------------
    // Tasks
    // ----------------------------------------------------
    task automatic cmp(input logic [DATA_W-1:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_bit(input logic got, exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic expire();
        miscompares++;
        finish_test();
    endtask : expire
    task automatic do_req(input logic we, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        int i;
        @(posedge clk);
        notes.push_back(dpr_note_t'{!we, we && a == MBOX_ADDR_DEF,
                                    we ? d : shadow[a]});
        if (we)
            shadow[a] = d;
        req <= '{we, a, d};
        req_valid <= 1'b1;
        for (i = 0; i < 60; i++)
        begin
            @(posedge clk);
            if (req_ready === 1'b1)
                break;
        end
        if (i == 60)
            expire();
        req_valid <= 1'b0;
    endtask : do_req
    task automatic drain();
        int i;
        for (i = 0; i < 80 && notes.size() != 0; i++)
            @(posedge clk);
        if (notes.size() != 0)
            expire();
    endtask : drain
    task automatic wait_flag(input logic exp);
        int i;
        for (i = 0; i < 6 && mbox_flag !== exp; i++)
            @(posedge clk);
        cmp_bit(mbox_flag, exp);
    endtask : wait_flag
    // ----------------------------------------------------
    // Result watcher
    // ----------------------------------------------------
    always @(posedge clk)
        if (ack === 1'b1)
        begin
            if (notes.size() == 0)
                expire();
            head = notes.pop_front();
            if (head.rd)
                cmp(rdata, head.data);
            cmp_bit(mbox_sent, head.sent);
        end
    // ----------------------------------------------------
    // Main sequence
    // ----------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            adr[k] = ADDR_W'($random(seed));
            do_req(1'b1, adr[k], DATA_W'($random(seed)));
        end
        for (int k = 7; k >= 0; k--)
            do_req(1'b0, adr[k], DATA_RST);
        drain();
        $display("test back to back done");
        for (int k = 1; k >= 0; k--)
        begin
            clash <= 1'b1;
            do_req(k[0], 10'h155, 8'hA5);
            repeat (5) @(posedge clk);
            clash <= 1'b0;
            drain();
        end
        $display("test busy done");
        wait_flag(1'b0);
        far_addr <= MBOX_ADDR_DEF;
        far_data <= 8'h3C;
        far_wr <= 1'b1;
        shadow[MBOX_ADDR_DEF] = 8'h3C;
        @(posedge clk);
        far_wr <= 1'b0;
        wait_flag(1'b1);
        do_req(1'b0, MBOX_ADDR_DEF, DATA_RST);
        drain();
        wait_flag(1'b0);
        do_req(1'b1, MBOX_ADDR_DEF, 8'hC3);
        drain();
        $display("test mailbox done");
        finish_test();
    end
endmodule : test_dual_port_ram_busy_interrupt
